// File: common/standby_pkg.sv
// Constants, register map and state codes of the standby release controller
package standby_pkg;
	// Register byte offsets on the APB slave
	localparam logic [7:0] CTRL_OFS = 8'h00;
	localparam logic [7:0] STAT_OFS = 8'h04;
	// Control register field positions
	localparam int EXTCLK_BIT = 0;
	localparam int LSSTOP_BIT = 1;
	localparam int LSRUN_BIT = 2;
	localparam int OSC_SEL_LO = 3;
	localparam int T8EXT_BIT = 6;
	localparam int ITSRC_LO = 7;
	localparam int UARTT8_BIT = 9;
	localparam int T8EN_BIT = 10;
	localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
	localparam logic [31:0] CTRL_RST = 32'h0000_0004;
	// Interval timer count source codes; only the main-clock one is 2'h3
	localparam logic [1:0] ITSRC_MAIN = 2'h3;
	// Release waits in clocks, the shorter of each documented pair
	localparam logic [19:0] HALT_VEC_WAIT = 20'h0_000B;
	localparam logic [19:0] HALT_RES_WAIT = 20'h0_0004;
	localparam logic [19:0] STOP_VEC_WAIT = 20'h0_0011;
	localparam logic [19:0] STOP_RES_WAIT = 20'h0_000B;
	// Voltage stabilisation, least time rounded up to clocks
	localparam int CLK_NS = 50;
	localparam int VSTAB_NS = 1610000;
	localparam int VSTAB_CYCLES = (VSTAB_NS + CLK_NS - 1) / CLK_NS;
	// Oscillation stabilisation base count, scaled by the select field
	localparam int OSC_BASE_CYCLES = 2048;
	// Controller states
	typedef enum logic [2:0] {
		ST_RUN = 3'b000,
		ST_HALT = 3'b001,
		ST_STOP = 3'b010,
		ST_OSC = 3'b011,
		ST_REL = 3'b100,
		ST_VOLT = 3'b101
	} state_e;
	// What follows the current wait
	typedef enum logic [1:0] {
		K_RES = 2'b00,
		K_VEC = 2'b01,
		K_RST = 2'b10
	} kind_e;
endpackage

// File: src/standby_release_control.sv
// Halt and stop standby control with release waits and peripheral gating
//
// Local design decisions: the address map and the APB slave port.
`timescale 1ns/1ns
`default_nettype none

// What this block does
// (R1) Unmasked interrupt ends halt, then vectors or resumes next instruction
// (R2) Halt release waits 11 clocks before vectoring, 4 before resuming
// (R3) Any reset ends halt or stop and leads to reset vector processing
// (R4) Pin or power-on-clear reset waits 1.61 ms for voltage before processing
// (R5) No oscillation wait after reset when main clock is external
// (R6) Vector if enabled; priority-flagged request also needs in-service flag set
// (R7) Stop entered only by stop instruction while on main system clock
// (R8) Pending unmasked request at stop turns it to halt plus oscillation wait
// (R9) Stop cuts CPU clock, both fast oscillators and the external clock input
// (R10) Stop keeps low-speed oscillator state; memories and port latches retained
// (R11) Stop halts 16-bit timer, converter and comparator
// (R12) 8-bit timer counts in stop only from its external input pin
// (R13) Interval timer counts in stop only from low-speed clock sources
// (R14) Watchdog runs in stop unless low-speed oscillator is software-stoppable
// (R15) Serial unit runs in stop only clocked by running 8-bit timer output
// (R16) Stop release by interrupt completes after oscillation wait, then vectors/resumes
module standby_release_control
	import standby_pkg::*;
#(
	parameter int unsigned VSTAB_CYC = VSTAB_CYCLES,
	parameter int unsigned OSC_BASE_CYC = OSC_BASE_CYCLES
) (
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic [7:0] paddr_i,
	input wire logic psel_i,
	input wire logic penable_i,
	input wire logic pwrite_i,
	input wire logic [31:0] pwdata_i,
	output logic [31:0] prdata_o,
	output logic pready_o,
	output logic pslverr_o,
	input wire logic halt_exec_i,
	input wire logic stop_exec_i,
	input wire logic cpu_on_main_clk_i,
	input wire logic irq_request_i,
	input wire logic interrupt_mask_flag_i,
	input wire logic interrupt_priority_flag_i,
	input wire logic global_interrupt_enable_i,
	input wire logic in_service_priority_flag_i,
	input wire logic reset_req_i,
	input wire logic pin_or_power_on_reset_i,
	output logic cpu_clk_en_o,
	output logic vector_o,
	output logic resume_o,
	output logic reset_vector_o,
	output logic fast_internal_osc_en_o,
	output logic crystal_osc_en_o,
	output logic ext_clk_accept_o,
	output logic lowspeed_osc_run_o,
	output logic retain_o,
	output logic tmr16_run_o,
	output logic adc_run_o,
	output logic cmp_run_o,
	output logic tmr8_run_o,
	output logic itmr_run_o,
	output logic wdt_clk_en_o,
	output logic uart_run_o
);

	////////////////////////////////////////////////////////////////////////
	// Registers and control fields

	logic [31:0] ctrl;
	state_e state;
	state_e next_state;
	kind_e kind;
	kind_e next_kind;
	logic [19:0] cnt;
	logic [19:0] next_cnt;
	logic next_vec;
	logic next_res;
	logic next_rst;
	logic extclk;
	logic ls_stoppable;
	logic [2:0] osc_stabilise_time_select;
	logic [1:0] itsrc;
	logic [19:0] osc_cyc;
	logic wake;
	logic vec_dec;
	logic acc;

	assign extclk = ctrl[EXTCLK_BIT];
	assign ls_stoppable = ctrl[LSSTOP_BIT];
	assign osc_stabilise_time_select = ctrl[OSC_SEL_LO +: 3];
	assign itsrc = ctrl[ITSRC_LO +: 2];
	// Select above 4 saturates so the count never overflows
	assign osc_cyc = 20'(OSC_BASE_CYC) << ((osc_stabilise_time_select > 3'h4) ? 3'h4 :
		osc_stabilise_time_select);
	// Unmasked request wakes the core [R1]
	assign wake = irq_request_i && !interrupt_mask_flag_i;
	// Acknowledge decision per priority flag [R6]
	assign vec_dec = global_interrupt_enable_i &&
		(!interrupt_priority_flag_i || in_service_priority_flag_i);
	assign acc = psel_i && penable_i;

	////////////////////////////////////////////////////////////////////////
	// APB slave, one wait state, unmapped addresses answer with an error

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			pready_o <= 1'b0;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
		end else begin
			pready_o <= acc && !pready_o;
			pslverr_o <= 1'b0;
			prdata_o <= 32'h0000_0000;
			if (acc && !pready_o) begin
				if (paddr_i == CTRL_OFS) begin
					prdata_o <= pwrite_i ? 32'h0000_0000 : ctrl;
				end else if (paddr_i == STAT_OFS) begin
					prdata_o <= pwrite_i ? 32'h0000_0000 : {27'h000_0000, kind, state};
				end else begin
					pslverr_o <= 1'b1;
				end
			end
		end
	end

	// Control writes land on the completing edge only
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			ctrl <= CTRL_RST;
		end else if (acc && pready_o && pwrite_i && paddr_i == CTRL_OFS) begin
			ctrl <= pwdata_i & CTRL_MASK;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Standby sequencer; reset requests override everything else

	always_comb begin
		next_state = state;
		next_kind = kind;
		next_cnt = cnt;
		next_vec = 1'b0;
		next_res = 1'b0;
		next_rst = 1'b0;
		if (reset_req_i) begin
			next_kind = K_RST; // [R3]
			if (pin_or_power_on_reset_i) begin
				next_state = ST_VOLT; // [R4]
				next_cnt = 20'(VSTAB_CYC - 1);
			end else if (extclk) begin
				next_state = ST_RUN; // [R5]
				next_rst = 1'b1;
			end else begin
				next_state = ST_OSC;
				next_cnt = osc_cyc - 20'h0_0001;
			end
		end else begin
			case (state)
				ST_RUN: begin
					if (halt_exec_i) begin
						if (wake) begin
							next_state = ST_REL;
							next_kind = vec_dec ? K_VEC : K_RES;
							next_cnt = (vec_dec ? HALT_VEC_WAIT : HALT_RES_WAIT) - 20'h0_0001;
						end else begin
							next_state = ST_HALT;
						end
					end else if (stop_exec_i && cpu_on_main_clk_i) begin // [R7]
						if (wake) begin
							// Falls to halt; oscillators stay up but the wait runs [R8]
							next_state = ST_OSC;
							next_kind = vec_dec ? K_VEC : K_RES;
							next_cnt = osc_cyc - 20'h0_0001;
						end else begin
							next_state = ST_STOP;
						end
					end
				end
				ST_HALT: begin
					if (wake) begin
						next_state = ST_REL; // [R1]
						next_kind = vec_dec ? K_VEC : K_RES; // [R6]
						next_cnt = (vec_dec ? HALT_VEC_WAIT : HALT_RES_WAIT) - 20'h0_0001; // [R2]
					end
				end
				ST_STOP: begin
					if (wake) begin
						next_state = ST_OSC; // [R16]
						next_kind = vec_dec ? K_VEC : K_RES;
						next_cnt = osc_cyc - 20'h0_0001;
					end
				end
				ST_OSC: begin
					if (cnt != 20'h0_0000) begin
						next_cnt = cnt - 20'h0_0001;
					end else if (kind == K_RST) begin
						next_state = ST_RUN;
						next_rst = 1'b1;
					end else begin
						next_state = ST_REL; // [R16]
						next_cnt = ((kind == K_VEC) ? STOP_VEC_WAIT : STOP_RES_WAIT) - 20'h0_0001;
					end
				end
				ST_VOLT: begin
					if (cnt != 20'h0_0000) begin
						next_cnt = cnt - 20'h0_0001; // [R4]
					end else if (extclk) begin
						next_state = ST_RUN; // [R5]
						next_rst = 1'b1;
					end else begin
						next_state = ST_OSC;
						next_cnt = osc_cyc - 20'h0_0001;
					end
				end
				ST_REL: begin
					if (cnt != 20'h0_0000) begin
						next_cnt = cnt - 20'h0_0001;
					end else begin
						next_state = ST_RUN; // [R1]
						next_vec = (kind == K_VEC);
						next_res = (kind != K_VEC);
					end
				end
				default: begin
					next_state = ST_RUN;
				end
			endcase
		end
	end

	// Sequencer state
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			state <= ST_RUN;
			kind <= K_RES;
			cnt <= 20'h0_0000;
		end else begin
			state <= next_state;
			kind <= next_kind;
			cnt <= next_cnt;
		end
	end

	// Core-facing strobes and clock gate, registered from the next state
	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			cpu_clk_en_o <= 1'b1;
			vector_o <= 1'b0;
			resume_o <= 1'b0;
			reset_vector_o <= 1'b0;
		end else begin
			cpu_clk_en_o <= (next_state == ST_RUN);
			vector_o <= next_vec;
			resume_o <= next_res;
			reset_vector_o <= next_rst; // [R3]
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Clock source and peripheral gating; stop removes clocks, and control bits also gate the low-speed oscillator and 8-bit timer

	always_ff @(posedge clk_i) begin
		if (!resetn_i) begin
			fast_internal_osc_en_o <= 1'b1;
			crystal_osc_en_o <= 1'b1;
			ext_clk_accept_o <= 1'b1;
			lowspeed_osc_run_o <= 1'b1;
			retain_o <= 1'b0;
			tmr16_run_o <= 1'b1;
			adc_run_o <= 1'b1;
			cmp_run_o <= 1'b1;
			tmr8_run_o <= 1'b0;
			itmr_run_o <= 1'b1;
			wdt_clk_en_o <= 1'b1;
			uart_run_o <= 1'b1;
		end else begin
			fast_internal_osc_en_o <= (next_state != ST_STOP); // [R9]
			crystal_osc_en_o <= (next_state != ST_STOP); // [R9]
			ext_clk_accept_o <= (next_state != ST_STOP); // [R9]
			// Stop leaves it as software set it [R10]
			lowspeed_osc_run_o <= !ls_stoppable || ctrl[LSRUN_BIT];
			retain_o <= (next_state != ST_RUN); // [R10]
			tmr16_run_o <= (next_state != ST_STOP); // [R11]
			adc_run_o <= (next_state != ST_STOP); // [R11]
			cmp_run_o <= (next_state != ST_STOP); // [R11]
			tmr8_run_o <= ctrl[T8EN_BIT] &&
				((next_state != ST_STOP) || ctrl[T8EXT_BIT]); // [R12]
			itmr_run_o <= (next_state != ST_STOP) || (itsrc != ITSRC_MAIN); // [R13]
			// Software-stoppable option removes the watchdog clock in stop only [R14]
			wdt_clk_en_o <= !(ls_stoppable && (next_state == ST_STOP));
			// Timer output as serial clock only helps if that timer runs [R15]
			uart_run_o <= (next_state != ST_STOP) || (ctrl[UARTT8_BIT] &&
				ctrl[T8EN_BIT] && ctrl[T8EXT_BIT]);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks

	default clocking cb @(posedge clk_i);
	endclocking

	a_halt_vec_wait: assert property (disable iff (!resetn_i || reset_req_i) // [R2]
		(state == ST_HALT && wake && vec_dec) |-> !cpu_clk_en_o [*1] ##12 vector_o)
		else $error("halt vectoring wait is not 11 clocks");

	a_halt_res_wait: assert property (disable iff (!resetn_i || reset_req_i) // [R2]
		(state == ST_HALT && wake && !vec_dec) |-> ##5 (resume_o && cpu_clk_en_o))
		else $error("halt resume wait is not 4 clocks");

	a_ack_choice: assert property (disable iff (!resetn_i) // [R6]
		(state == ST_HALT && wake && !reset_req_i) |=> ((kind == K_VEC) == $past(vec_dec)))
		else $error("vectoring decision wrong");

	a_halt_held: assert property (disable iff (!resetn_i) // [R1]
		(state == ST_HALT && !wake && !reset_req_i) |=> (state == ST_HALT && !cpu_clk_en_o))
		else $error("halt left without unmasked request");

	a_reset_direct: assert property (disable iff (!resetn_i) // [R3]
		(reset_req_i && !pin_or_power_on_reset_i && extclk) |=> (reset_vector_o && cpu_clk_en_o))
		else $error("reset did not reach reset vector");

	a_volt_start: assert property (disable iff (!resetn_i) // [R4]
		(reset_req_i && pin_or_power_on_reset_i) |=> (state == ST_VOLT &&
		cnt == 20'(VSTAB_CYC - 1)
		&& !reset_vector_o))
		else $error("voltage wait not loaded");

	a_extclk_skip: assert property (disable iff (!resetn_i) // [R5]
		(state == ST_VOLT && cnt == 20'h0_0000 && extclk && !reset_req_i)
		|=> reset_vector_o)
		else $error("oscillation wait not skipped");

	a_stop_entry: assert property (disable iff (!resetn_i) // [R7]
		(state == ST_RUN && stop_exec_i && !cpu_on_main_clk_i && !halt_exec_i
		&& !reset_req_i) |=> state == ST_RUN)
		else $error("stop entered off main clock");

	a_stop_pending: assert property (disable iff (!resetn_i) // [R8]
		(state == ST_RUN && stop_exec_i && cpu_on_main_clk_i && wake && !halt_exec_i
		&& !reset_req_i) |=> (state == ST_OSC && fast_internal_osc_en_o))
		else $error("pending request did not cancel stop");

	a_stop_clocks: assert property (disable iff (!resetn_i) // [R9]
		(state == ST_STOP) |-> !(cpu_clk_en_o || fast_internal_osc_en_o ||
		crystal_osc_en_o || ext_clk_accept_o))
		else $error("clock running in stop");

	a_stop_periph: assert property (disable iff (!resetn_i) // [R11]
		(state == ST_STOP) |-> !(tmr16_run_o || adc_run_o || cmp_run_o))
		else $error("main clock peripheral running in stop");

	a_stop_wake: assert property (disable iff (!resetn_i) // [R16]
		(state == ST_STOP && wake && !reset_req_i) |=> (state == ST_OSC && !vector_o
		&& !resume_o))
		else $error("stop release skipped oscillation wait");

endmodule

`default_nettype wire

// File: bench/core_flags_model.sv
// Behavioural CPU core and interrupt controller flag source
`timescale 1ns/1ns
`default_nettype none
module core_flags_model (
	input wire logic clk_i,
	input wire logic vector_i,
	input wire logic resume_i,
	output logic halt_o,
	output logic stop_o,
	output logic main_clk_o,
	output logic req_o,
	output logic mask_o,
	output logic prio_o,
	output logic enable_o,
	output logic in_service_o
);
	// Idle core on the main clock, nothing pending
	initial begin
		{halt_o, stop_o, req_o, mask_o, prio_o, enable_o, in_service_o} = '0;
		main_clk_o = 1'b1;
	end
	// Servicing consumes the request, as a real core clears its flag
	always @(posedge clk_i) begin
		if (vector_i || resume_i) begin
			req_o <= 1'b0;
		end
	end
	////////////////////////////////////////////////////////////
	// One-cycle instruction pulse; s picks stop over halt
	task automatic instr(input logic s, input logic mc);
		@(posedge clk_i);
		halt_o <= !s;
		stop_o <= s;
		main_clk_o <= mc;
		@(posedge clk_i);
		halt_o <= 1'b0;
		stop_o <= 1'b0;
	endtask
	// Request level with its qualifying flags, changed just after an edge
	task automatic req(input logic r, input logic m, input logic p, input logic e, input logic i);
		@(posedge clk_i);
		req_o <= r;
		mask_o <= m;
		prio_o <= p;
		enable_o <= e;
		in_service_o <= i;
	endtask
endmodule
`default_nettype wire

// File: bench/tb_standby_release_control.sv
// Self-checking bench of the standby release controller
`timescale 1ns/1ns
`default_nettype none
module tb_standby_release_control
	import standby_pkg::*;
;
	logic clk_i, resetn_i, psel_i, penable_i, pwrite_i, reset_req_i, pin_or_power_on_reset_i;
	logic [7:0] paddr_i;
	logic [31:0] pwdata_i, prdata_o, rd;
	logic pready_o, pslverr_o, halt_exec_i, stop_exec_i, cpu_on_main_clk_i, irq_request_i, er;
	logic interrupt_mask_flag_i, interrupt_priority_flag_i, global_interrupt_enable_i;
	logic in_service_priority_flag_i, cpu_clk_en_o, vector_o, resume_o, reset_vector_o;
	logic fast_internal_osc_en_o, crystal_osc_en_o, ext_clk_accept_o, lowspeed_osc_run_o;
	logic retain_o, tmr16_run_o, adc_run_o, cmp_run_o, tmr8_run_o, itmr_run_o, wdt_clk_en_o;
	logic uart_run_o;
	int errors = 0, tests_run = 0, cyc = 0, n;
	// Shortened voltage and oscillation waits keep the run brief
	localparam int VS = 20;
	localparam int OB = 4;
	standby_release_control #(.VSTAB_CYC(VS), .OSC_BASE_CYC(OB)) i_standby_release_control (
		.clk_i, .resetn_i, .paddr_i, .psel_i, .penable_i, .pwrite_i, .pwdata_i, .prdata_o,
		.pready_o, .pslverr_o, .halt_exec_i, .stop_exec_i, .cpu_on_main_clk_i, .irq_request_i,
		.interrupt_mask_flag_i, .interrupt_priority_flag_i, .global_interrupt_enable_i,
		.in_service_priority_flag_i, .reset_req_i, .pin_or_power_on_reset_i, .cpu_clk_en_o,
		.vector_o, .resume_o, .reset_vector_o, .fast_internal_osc_en_o, .crystal_osc_en_o,
		.ext_clk_accept_o, .lowspeed_osc_run_o, .retain_o, .tmr16_run_o, .adc_run_o,
		.cmp_run_o, .tmr8_run_o, .itmr_run_o, .wdt_clk_en_o, .uart_run_o);
	core_flags_model i_core_flags_model (.clk_i, .vector_i(vector_o), .resume_i(resume_o),
		.halt_o(halt_exec_i), .stop_o(stop_exec_i), .main_clk_o(cpu_on_main_clk_i),
		.req_o(irq_request_i), .mask_o(interrupt_mask_flag_i),
		.prio_o(interrupt_priority_flag_i), .enable_o(global_interrupt_enable_i),
		.in_service_o(in_service_priority_flag_i));
	////////////////////////////////////////////////////////////
	// Clock and hang guard
	initial clk_i = 1'b0;
	always #25 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cyc <= cyc + 1;
		if (cyc == 4000) begin
			errors++;
			test_done();
		end
	end
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		tests_run++;
		if (got !== exp) begin
			errors++;
			$display("wrong value at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic test_done();
		$display("comparisons %0d mismatches %0d", tests_run, errors);
		if (errors == 0 && tests_run > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask
	// APB transfer; request held until pready is seen at an edge
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		@(posedge clk_i);
		{psel_i, penable_i, pwrite_i, paddr_i, pwdata_i} <= {2'b10, w, a, d};
		@(posedge clk_i);
		penable_i <= 1'b1;
		// Only the bench timeout ends a wait that never sees pready
		do begin
			@(posedge clk_i);
		end while (pready_o !== 1'b1);
		rd = prdata_o;
		er = pslverr_o;
		{psel_i, penable_i} <= 2'b00;
	endtask
	// Edges until the chosen pulse: 0 vector, 1 resume, 2 reset vector
	task automatic count_to(input int w);
		n = 0;
		do begin
			@(posedge clk_i);
			#1;
			n++;
		end while ((w == 0 ? vector_o : w == 1 ? resume_o : reset_vector_o) !== 1'b1 && n < 400);
	endtask
	////////////////////////////////////////////////////////////
	task automatic t_reset();
		#1;
		check(32'({cpu_clk_en_o, tmr8_run_o, retain_o}), 32'h0000_0004);
		apb(1'b0, CTRL_OFS, 32'h0000_0000);
		check(rd, CTRL_RST);
		apb(1'b1, CTRL_OFS, 32'hFFFF_FFFF);
		apb(1'b0, CTRL_OFS, 32'h0000_0000);
		check(rd, CTRL_MASK);
		apb(1'b0, 8'h08, 32'h0000_0000);
		check(32'(er), 32'h0000_0001);
		$display("reset and register test done");
	endtask
	// Halt release over the decision table: {priority, enable, in-service, vectors}
	task automatic t_halt();
		logic [3:0] tab [5] = '{4'h5, 4'h2, 4'hF, 4'hC, 4'hA};
		foreach (tab[k]) begin
			i_core_flags_model.instr(1'b0, 1'b1);
			#1;
			check(32'(cpu_clk_en_o), 32'h0000_0000);
			i_core_flags_model.req(1'b1, 1'b0, tab[k][3], tab[k][2], tab[k][1]);
			count_to(tab[k][0] ? 0 : 1);
			check(n, 32'(tab[k][0] ? HALT_VEC_WAIT : HALT_RES_WAIT) + 1);
			check(32'(cpu_clk_en_o), 32'h0000_0001);
			repeat (2) @(posedge clk_i);
		end
		$display("halt release test done");
	endtask
	// Stop refused off the main clock, then entered, gated and released
	task automatic t_stop(input logic [31:0] cfg, input logic [12:0] exp, input logic v,
		input int osc);
		apb(1'b1, CTRL_OFS, cfg);
		i_core_flags_model.instr(1'b1, 1'b0);
		#1;
		check(32'(cpu_clk_en_o), 32'h0000_0001);
		i_core_flags_model.instr(1'b1, 1'b1);
		#1;
		check(32'({cpu_clk_en_o, fast_internal_osc_en_o, crystal_osc_en_o, ext_clk_accept_o,
			lowspeed_osc_run_o, retain_o, tmr16_run_o, adc_run_o, cmp_run_o, tmr8_run_o,
			itmr_run_o, wdt_clk_en_o, uart_run_o}), 32'(exp));
		i_core_flags_model.req(1'b1, 1'b0, 1'b0, v, 1'b0);
		count_to(v ? 0 : 1);
		check(n, 1 + osc + (v ? STOP_VEC_WAIT : STOP_RES_WAIT));
		repeat (2) @(posedge clk_i);
		$display("stop test done");
	endtask
	// Stop with a request already pending falls to halt, oscillators kept
	task automatic t_pending();
		i_core_flags_model.req(1'b1, 1'b0, 1'b0, 1'b0, 1'b0);
		i_core_flags_model.instr(1'b1, 1'b1);
		#1;
		check(32'({cpu_clk_en_o, fast_internal_osc_en_o, crystal_osc_en_o}), 32'h0000_0003);
		count_to(1);
		check(n, 2 * OB + STOP_RES_WAIT);
		$display("pending stop test done");
	endtask
	// One reset pulse; the exact edge of the count may slip by one
	task automatic rst(input logic p, input int lo);
		@(posedge clk_i);
		{reset_req_i, pin_or_power_on_reset_i} <= {1'b1, p};
		@(posedge clk_i);
		{reset_req_i, pin_or_power_on_reset_i} <= 2'b00;
		#1;
		// A direct reset pulses at the sampling edge itself, count zero
		n = 0;
		if (reset_vector_o !== 1'b1) begin
			count_to(2);
		end
		check(32'(n >= lo && n <= lo + 1), 32'h0000_0001);
	endtask
	task automatic t_resets();
		apb(1'b1, CTRL_OFS, 32'h0000_0001);
		i_core_flags_model.instr(1'b0, 1'b1);
		i_core_flags_model.req(1'b1, 1'b1, 1'b0, 1'b1, 1'b0);
		repeat (30) @(posedge clk_i);
		#1;
		check(32'(cpu_clk_en_o), 32'h0000_0000);
		rst(1'b0, 0);
		i_core_flags_model.req(1'b0, 1'b0, 1'b0, 1'b0, 1'b0);
		rst(1'b1, VS);
		apb(1'b1, CTRL_OFS, 32'h0000_0000);
		rst(1'b0, OB);
		rst(1'b1, VS + OB);
		$display("reset release test done");
	endtask
	////////////////////////////////////////////////////////////
	initial begin
		{psel_i, penable_i, pwrite_i, reset_req_i, pin_or_power_on_reset_i, resetn_i} = '0;
		paddr_i = 8'h00;
		pwdata_i = 32'h0000_0000;
		repeat (8) @(posedge clk_i);
		resetn_i <= 1'b1;
		t_reset();
		t_halt();
		t_stop(32'h0000_07C2, 13'h0089, 1'b1, OB);
		t_stop(32'h0000_0408, 13'h0186, 1'b0, 2 * OB);
		t_pending();
		t_resets();
		test_done();
	end
endmodule
`default_nettype wire
